// >>> verilog/adcrs_pkg.sv
package adcrs_pkg;
   localparam logic [6:0] ADDR_CURRENT_RESULT_HIGH = 7'h00;
   localparam logic [6:0] ADDR_CURRENT_RESULT_LOW = 7'h01;
   localparam logic [6:0] ADDR_VOLTAGE_RESULT_HIGH = 7'h02;
   localparam logic [6:0] ADDR_VOLTAGE_RESULT_LOW = 7'h03;
   localparam logic [6:0] ADDR_MEASUREMENT_STATUS = 7'h04;
   localparam logic [6:0] ADDR_CURRENT_PATH_CONTROL_ONE = 7'h05;

   localparam logic [15:0] RESULT_RESET = 16'h0000;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] CONTROL_ONE_RESET = 8'h45;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   localparam int STAT_NORMAL_READY = 7;
   localparam int STAT_NORMAL_MODE_TWO_CROSS = 6;
   localparam int STAT_STANDBY_MODE_ONE_READY = 5;
   localparam int STAT_STANDBY_MODE_TWO_CROSS = 4;
   localparam int STAT_ANALOG_POWER_ON_RESET = 3;
   localparam int STAT_CURRENT_UPDATED = 2;
   localparam int STAT_VOLTAGE_UPDATED = 1;

   localparam int CTRL_DEC1_RATE = 7;
   localparam int CTRL_CHOP_MSB = 6;
   localparam int CTRL_CHOP_LSB = 5;
   localparam int CTRL_DEC2_MSB = 4;
   localparam int CTRL_DEC2_LSB = 1;
   localparam int CTRL_SAT_MASK = 0;

   localparam logic [1:0] CHOP_ALWAYS_HIGH = 2'h0;
   localparam logic [1:0] CHOP_DIV_256 = 2'h1;
   localparam logic [1:0] CHOP_DIV_512 = 2'h2;
   localparam logic [1:0] CHOP_DIV_1024 = 2'h3;
   localparam int CHOP_HALF_256 = 128;
   localparam int CHOP_HALF_512 = 256;
   localparam int CHOP_HALF_1024 = 512;
   localparam int CHOP_CNT_W = 9;

   localparam logic [2:0] PIN_SYNC_RESET = 3'h4;
endpackage : adcrs_pkg

// >>> verilog/adcrs_sync.sv
`timescale 1ns/1ns
module adcrs_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_q;

   initial begin
      if (WIDTH < 1) $error("adcrs_sync needs WIDTH of at least 1.");
   end

   // Two flip-flops per bit; the first is read by the second only.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         meta_q <= RESET_VAL;
         o_sync <= RESET_VAL;
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule : adcrs_sync

// >>> verilog/adcrs_chop_div.sv
`timescale 1ns/1ns
module adcrs_chop_div
   import adcrs_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_mod_tick,
   input wire logic [1:0] i_div_sel,
   output logic o_chopper_clock
);
   logic [CHOP_CNT_W-1:0] cnt_q;
   logic [CHOP_CNT_W-1:0] half_m1;

   always_comb begin
      unique case (i_div_sel)
         CHOP_DIV_256: half_m1 = CHOP_CNT_W'(CHOP_HALF_256 - 1);
         CHOP_DIV_512: half_m1 = CHOP_CNT_W'(CHOP_HALF_512 - 1);
         CHOP_DIV_1024: half_m1 = CHOP_CNT_W'(CHOP_HALF_1024 - 1);
         CHOP_ALWAYS_HIGH: half_m1 = '0;
      endcase
   end

   // Toggles every half period of modulator ticks, or sits high for code 00.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt_q <= '0;
         o_chopper_clock <= 1'b1;
      end else if (i_div_sel == CHOP_ALWAYS_HIGH) begin
         cnt_q <= '0;
         o_chopper_clock <= 1'b1;
      end else if (i_mod_tick) begin
         if (cnt_q >= half_m1) begin
            cnt_q <= '0;
            o_chopper_clock <= ~o_chopper_clock;
         end else begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end
endmodule : adcrs_chop_div

// >>> verilog/adcrs_regs.sv
`timescale 1ns/1ns
module adcrs_regs
   import adcrs_pkg::*;
#(
   parameter int RESULT_W = 16
) (
   input wire logic I_SYS_CLK,
   input wire logic I_RSTN,
   input wire logic I_SPI_CS_N,
   input wire logic I_SPI_SCLK,
   input wire logic I_SPI_MOSI,
   output logic O_SPI_MISO,
   output logic O_SPI_MISO_OE_N,
   input wire logic [RESULT_W-1:0] I_CURRENT_RESULT,
   input wire logic I_CURRENT_STROBE,
   input wire logic [RESULT_W-1:0] I_VOLTAGE_RESULT,
   input wire logic I_VOLTAGE_STROBE,
   input wire logic I_NORMAL_READY,
   input wire logic I_NORMAL_MODE_TWO_CROSS,
   input wire logic I_STANDBY_MODE_ONE_READY,
   input wire logic I_STANDBY_MODE_TWO_CROSS,
   input wire logic I_ANALOG_POWER_ON_RESET,
   input wire logic I_MODULATOR_CLOCK_TICK,
   output logic O_DEC1_RATE_128,
   output logic O_CHOPPER_CLOCK,
   output logic [3:0] O_DEC2_CODE,
   output logic [15:0] O_DEC2_RATIO,
   output logic O_SAT_INT_MASK
);
   initial begin
      if (RESULT_W != 16) $error("adcrs_regs serves 16-bit results only.");
   end

   logic [2:0] pins_s;
   logic cs_n_s;
   logic sclk_s;
   logic mosi_s;
   logic cs_n_prev_q;
   logic sclk_prev_q;
   logic sample_rise_q;
   logic active;
   logic sclk_rise;
   logic sclk_fall;
   logic sample_edge;
   logic shift_edge;
   logic in_data_q;
   logic is_read_q;
   logic [2:0] bit_cnt_q;
   logic [7:0] rx_q;
   logic [7:0] rx_d;
   logic [7:0] tx_q;
   logic [6:0] addr_q;
   logic byte_done;
   logic cmd_done;
   logic data_done;
   logic load_read;
   logic [6:0] load_addr;
   logic [7:0] load_data;
   logic wr_stb;
   logic status_read;
   logic [15:0] current_q;
   logic [15:0] voltage_q;
   logic [7:0] status_q;
   logic [7:0] control_q;

   adcrs_sync #(
      .WIDTH(3),
      .RESET_VAL(PIN_SYNC_RESET)
   ) u_pin_sync (
      .i_clk(I_SYS_CLK),
      .i_rstn(I_RSTN),
      .i_async({I_SPI_CS_N, I_SPI_SCLK, I_SPI_MOSI}),
      .o_sync(pins_s)
   );

   assign cs_n_s = pins_s[2];
   assign sclk_s = pins_s[1];
   assign mosi_s = pins_s[0];

   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         cs_n_prev_q <= 1'b1;
         sclk_prev_q <= 1'b0;
      end else begin
         cs_n_prev_q <= cs_n_s;
         sclk_prev_q <= sclk_s;
      end
   end

   // The clock level at the chip select fall chooses the sampling edge.
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         sample_rise_q <= 1'b1;
      end else if (cs_n_prev_q && !cs_n_s) begin
         sample_rise_q <= sclk_s;
      end
   end

   assign active = !cs_n_s && !cs_n_prev_q;
   assign sclk_rise = !sclk_prev_q && sclk_s;
   assign sclk_fall = sclk_prev_q && !sclk_s;
   assign sample_edge = active && (sample_rise_q ? sclk_rise : sclk_fall);
   assign shift_edge = active && (sample_rise_q ? sclk_fall : sclk_rise);

   assign rx_d = {rx_q[6:0], mosi_s};
   assign byte_done = sample_edge && (bit_cnt_q == 3'h7);
   assign cmd_done = byte_done && !in_data_q;
   assign data_done = byte_done && in_data_q;
   assign wr_stb = data_done && !is_read_q;
   assign load_read = (cmd_done && rx_d[7]) || (data_done && is_read_q);
   assign load_addr = cmd_done ? rx_d[6:0] : addr_q + 7'h01;
   assign status_read = load_read && (load_addr == ADDR_MEASUREMENT_STATUS);

   always_comb begin
      unique case (load_addr)
         ADDR_CURRENT_RESULT_HIGH: load_data = current_q[15:8];
         ADDR_CURRENT_RESULT_LOW: load_data = current_q[7:0];
         ADDR_VOLTAGE_RESULT_HIGH: load_data = voltage_q[15:8];
         ADDR_VOLTAGE_RESULT_LOW: load_data = voltage_q[7:0];
         ADDR_MEASUREMENT_STATUS: load_data = status_q;
         ADDR_CURRENT_PATH_CONTROL_ONE: load_data = control_q;
         default: load_data = UNMAPPED_READ;
      endcase
   end

   // Frame tracking: command byte first, then data bytes.
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         in_data_q <= 1'b0;
         is_read_q <= 1'b0;
         bit_cnt_q <= 3'h0;
         rx_q <= 8'h00;
         addr_q <= 7'h00;
      end else if (cs_n_s) begin
         in_data_q <= 1'b0;
         bit_cnt_q <= 3'h0;
      end else if (sample_edge) begin
         rx_q <= rx_d;
         bit_cnt_q <= bit_cnt_q + 3'h1;
         if (cmd_done) begin
            in_data_q <= 1'b1;
            is_read_q <= rx_d[7];
            addr_q <= rx_d[6:0];
         end else if (data_done) begin
            addr_q <= addr_q + 7'h01;
         end
      end
   end

   // Read data is loaded at a byte end and driven on each transfer edge.
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         tx_q <= 8'h00;
         O_SPI_MISO <= 1'b0;
      end else if (load_read) begin
         tx_q <= load_data;
      end else if (shift_edge) begin
         O_SPI_MISO <= tx_q[7];
         tx_q <= {tx_q[6:0], 1'b0};
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_SPI_MISO_OE_N <= 1'b1;
      end else begin
         O_SPI_MISO_OE_N <= !(active && in_data_q && is_read_q);
      end
   end

   // Result registers follow the conversion strobes only.
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         current_q <= RESULT_RESET;
         voltage_q <= RESULT_RESET;
      end else begin
         if (I_CURRENT_STROBE) begin
            current_q <= I_CURRENT_RESULT;
         end
         if (I_VOLTAGE_STROBE) begin
            voltage_q <= I_VOLTAGE_RESULT;
         end
      end
   end

   // Event flags clear when status is read; a new event in that cycle wins.
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         status_q <= STATUS_RESET;
      end else begin
         status_q[STAT_NORMAL_READY] <= I_NORMAL_READY
            || (status_q[STAT_NORMAL_READY] && !status_read);
         status_q[STAT_NORMAL_MODE_TWO_CROSS] <= I_NORMAL_MODE_TWO_CROSS
            || (status_q[STAT_NORMAL_MODE_TWO_CROSS] && !status_read);
         status_q[STAT_STANDBY_MODE_ONE_READY] <= I_STANDBY_MODE_ONE_READY
            || (status_q[STAT_STANDBY_MODE_ONE_READY] && !status_read);
         status_q[STAT_STANDBY_MODE_TWO_CROSS] <= I_STANDBY_MODE_TWO_CROSS
            || (status_q[STAT_STANDBY_MODE_TWO_CROSS] && !status_read);
         status_q[STAT_ANALOG_POWER_ON_RESET] <= I_ANALOG_POWER_ON_RESET;
         status_q[STAT_CURRENT_UPDATED] <= I_CURRENT_STROBE
            || (status_q[STAT_CURRENT_UPDATED] && !status_read);
         status_q[STAT_VOLTAGE_UPDATED] <= I_VOLTAGE_STROBE
            || (status_q[STAT_VOLTAGE_UPDATED] && !status_read);
         status_q[0] <= 1'b0;
      end
   end

   // Only the control register accepts writes.
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         control_q <= CONTROL_ONE_RESET;
      end else if (wr_stb && addr_q == ADDR_CURRENT_PATH_CONTROL_ONE) begin
         control_q <= rx_d;
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_DEC1_RATE_128 <= CONTROL_ONE_RESET[CTRL_DEC1_RATE];
         O_DEC2_CODE <= CONTROL_ONE_RESET[CTRL_DEC2_MSB:CTRL_DEC2_LSB];
         O_DEC2_RATIO <= 16'h0001 << CONTROL_ONE_RESET[CTRL_DEC2_MSB:CTRL_DEC2_LSB];
         O_SAT_INT_MASK <= CONTROL_ONE_RESET[CTRL_SAT_MASK];
      end else begin
         O_DEC1_RATE_128 <= control_q[CTRL_DEC1_RATE];
         O_DEC2_CODE <= control_q[CTRL_DEC2_MSB:CTRL_DEC2_LSB];
         O_DEC2_RATIO <= 16'h0001 << control_q[CTRL_DEC2_MSB:CTRL_DEC2_LSB];
         O_SAT_INT_MASK <= control_q[CTRL_SAT_MASK];
      end
   end

   adcrs_chop_div u_chop_div (
      .i_clk(I_SYS_CLK),
      .i_rstn(I_RSTN),
      .i_mod_tick(I_MODULATOR_CLOCK_TICK),
      .i_div_sel(control_q[CTRL_CHOP_MSB:CTRL_CHOP_LSB]),
      .o_chopper_clock(O_CHOPPER_CLOCK)
   );
endmodule : adcrs_regs

// >>> testbench/adcrs_assertions.sv
`timescale 1ns/1ns
module adcrs_assertions #(
   parameter int RESULT_W = 16
) (
   input wire logic I_SYS_CLK,
   input wire logic I_RSTN,
   input wire logic I_SPI_CS_N,
   input wire logic I_SPI_SCLK,
   input wire logic O_SPI_MISO,
   input wire logic O_SPI_MISO_OE_N,
   input wire logic I_MODULATOR_CLOCK_TICK,
   input wire logic O_DEC1_RATE_128,
   input wire logic O_CHOPPER_CLOCK,
   input wire logic [3:0] O_DEC2_CODE,
   input wire logic [15:0] O_DEC2_RATIO,
   input wire logic O_SAT_INT_MASK
);
   default clocking cb @(posedge I_SYS_CLK);
   endclocking
   default disable iff (!I_RSTN);
   a_reset_ctrl_values: assert property ($rose(I_RSTN) |-> O_DEC2_CODE == 4'h2
      && O_DEC2_RATIO == 16'h0004 && O_SAT_INT_MASK && !O_DEC1_RATE_128 && O_CHOPPER_CLOCK)
      else $error("control outputs wrong after reset");
   a_ratio_power_two: assert property (O_DEC2_RATIO == 16'h0001 << O_DEC2_CODE)
      else $error("second stage ratio does not match code");
   a_ctrl_spi_only: assert property ($changed({O_DEC1_RATE_128, O_DEC2_CODE,
      O_SAT_INT_MASK}) |-> !$past(I_SPI_CS_N, 5))
      else $error("control changed without a frame");
   a_chop_fall_tick: assert property ($fell(O_CHOPPER_CLOCK) |->
      $past(I_MODULATOR_CLOCK_TICK) || $past(I_MODULATOR_CLOCK_TICK, 2))
      else $error("chopper clock fell without a tick");
   a_oe_idle_cs: assert property (I_SPI_CS_N [*6] |-> O_SPI_MISO_OE_N)
      else $error("data out driven while deselected");
   a_oe_fall_cs: assert property ($fell(O_SPI_MISO_OE_N) |-> !$past(I_SPI_CS_N, 3))
      else $error("data out enabled without chip select");
   a_oe_low_read: assert property (!O_SPI_MISO_OE_N |-> !$past(I_SPI_CS_N, 6))
      else $error("data out still driven long after deselect");
   a_miso_on_edge: assert property ($changed(O_SPI_MISO) |->
      $past({I_SPI_SCLK, I_SPI_CS_N}, 1) != $past({I_SPI_SCLK, I_SPI_CS_N}, 7))
      else $error("data out changed without a clock edge");
endmodule : adcrs_assertions
bind adcrs_regs adcrs_assertions #(.RESULT_W(RESULT_W)) u_chk (
   .I_SYS_CLK(I_SYS_CLK), .I_RSTN(I_RSTN), .I_SPI_CS_N(I_SPI_CS_N),
   .I_SPI_SCLK(I_SPI_SCLK), .O_SPI_MISO(O_SPI_MISO), .O_SPI_MISO_OE_N(O_SPI_MISO_OE_N),
   .I_MODULATOR_CLOCK_TICK(I_MODULATOR_CLOCK_TICK), .O_DEC1_RATE_128(O_DEC1_RATE_128),
   .O_CHOPPER_CLOCK(O_CHOPPER_CLOCK), .O_DEC2_CODE(O_DEC2_CODE),
   .O_DEC2_RATIO(O_DEC2_RATIO), .O_SAT_INT_MASK(O_SAT_INT_MASK));

// >>> testbench/adcrs_spi_master.sv
`timescale 1ns/1ns
module adcrs_spi_master (
   input wire logic i_clk,
   output logic o_cs_n,
   output logic o_sclk,
   output logic o_mosi,
   input wire logic i_miso,
   input wire logic i_miso_oe_n,
   output logic o_miso_seen
);
   logic [7:0] txq[$];
   logic [7:0] rxq[$];
   logic last_q = 1'b0;
   // A released data line shows the inverse of its last driven level.
   assign o_miso_seen = i_miso_oe_n ? ~last_q : i_miso;
   always @(posedge i_clk) if (!i_miso_oe_n) last_q <= i_miso;
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_mosi = 1'b0;
   end
   task automatic half();
      repeat (10) @(posedge i_clk);
      #1;
   endtask : half
   task automatic frame(input logic idle_hi);
      logic [7:0] b;
      logic [7:0] r;
      o_sclk = idle_hi;
      half();
      o_cs_n = 1'b0;
      half();
      while (txq.size() > 0) begin
         b = txq.pop_front();
         for (int i = 7; i >= 0; i--) begin
            o_sclk = !idle_hi;
            o_mosi = b[i];
            half();
            r[i] = o_miso_seen;
            o_sclk = idle_hi;
            half();
         end
         rxq.push_back(r);
      end
      o_cs_n = 1'b1;
      half();
   endtask : frame
endmodule : adcrs_spi_master

// >>> testbench/test_adc_result_status_filter_regs.sv
`timescale 1ns/1ns
module test_adc_result_status_filter_regs;
   import adcrs_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [15:0] cur = '0;
   logic [15:0] vol = '0;
   logic [15:0] icur;
   logic [15:0] ivol;
   logic [15:0] ratio;
   logic [7:0] stat;
   logic [7:0] ctl;
   logic [3:0] flags = '0;
   logic [3:0] code;
   logic cur_stb = 1'b0;
   logic vol_stb = 1'b0;
   logic analog_power_on_reset = 1'b0;
   logic tick = 1'b0;
   logic tick_hold = 1'b0;
   logic cs_n, sclk, mosi, miso, oe_n, seen, rate, chop, mask;
   int failures = 0;
   int cmp_count = 0;
   initial forever #20 clk = ~clk;
   always @(posedge clk) #1 tick = tick_hold | 1'($urandom);
   adcrs_spi_master M (.i_clk(clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi),
      .i_miso(miso), .i_miso_oe_n(oe_n), .o_miso_seen(seen));
   adcrs_regs DUT (.I_SYS_CLK(clk), .I_RSTN(rstn), .I_SPI_CS_N(cs_n), .I_SPI_SCLK(sclk),
      .I_SPI_MOSI(mosi), .O_SPI_MISO(miso), .O_SPI_MISO_OE_N(oe_n),
      .I_CURRENT_RESULT(cur), .I_CURRENT_STROBE(cur_stb), .I_VOLTAGE_RESULT(vol),
      .I_VOLTAGE_STROBE(vol_stb), .I_NORMAL_READY(flags[3]), .I_NORMAL_MODE_TWO_CROSS(flags[2]),
      .I_STANDBY_MODE_ONE_READY(flags[1]), .I_STANDBY_MODE_TWO_CROSS(flags[0]),
      .I_ANALOG_POWER_ON_RESET(analog_power_on_reset), .I_MODULATOR_CLOCK_TICK(tick), .O_DEC1_RATE_128(rate),
      .O_CHOPPER_CLOCK(chop), .O_DEC2_CODE(code), .O_DEC2_RATIO(ratio), .O_SAT_INT_MASK(mask));
   task automatic give_verdict();
      if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : give_verdict
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   function automatic logic [7:0] model_rd(input int a);
      logic [7:0] v;
      case (a % 128)
         0: v = icur[15:8];
         1: v = icur[7:0];
         2: v = ivol[15:8];
         3: v = ivol[7:0];
         4: begin
            v = stat | {4'h0, analog_power_on_reset, 3'h0};
            stat = 8'h00;
         end
         5: v = ctl;
         default: v = 8'h00;
      endcase
      return v;
   endfunction : model_rd
   task automatic do_reset();
      rstn = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      rstn = 1'b1;
      icur = '0;
      ivol = '0;
      stat = 8'h00;
      ctl = 8'h45;
      repeat (3) @(posedge clk);
      #1;
   endtask : do_reset
   task automatic load();
      @(posedge clk);
      #1;
      cur = $urandom;
      vol = $urandom;
      flags = $urandom;
      {cur_stb, vol_stb} = 2'h3;
      @(posedge clk);
      #1;
      {cur_stb, vol_stb} = 2'h0;
      icur = cur;
      ivol = vol;
      stat = stat | {flags, 4'h6};
      flags = 4'h0;
   endtask : load
   task automatic rd(input logic hi, input int a, input int n);
      M.txq.push_back(8'(8'h80 | a));
      repeat (n) M.txq.push_back(8'h00);
      M.frame(hi);
      void'(M.rxq.pop_front());
      for (int i = 0; i < n; i++) check("read byte", model_rd(a + i), M.rxq.pop_front());
   endtask : rd
   task automatic wr(input logic hi, input int a, input int n, input logic [7:0] v);
      M.txq.push_back(8'(a));
      for (int i = 0; i < n; i++) begin
         M.txq.push_back(((a + i) % 128 == 5) ? v : 8'($urandom));
      end
      if ((a + n - 1) % 128 >= 5 || (a + n - 1) % 128 < a) ctl = v;
      M.frame(hi);
      void'(M.rxq.pop_front());
      repeat (n) void'(M.rxq.pop_front());
   endtask : wr
   task automatic chk_ctl();
      check("rate", 16'(ctl[7]), 16'(rate));
      check("code", 16'(ctl[4:1]), 16'(code));
      check("ratio", 16'h0001 << ctl[4:1], ratio);
      check("mask", 16'(ctl[0]), 16'(mask));
   endtask : chk_ctl
   task automatic wait_lvl(input logic v, output int n);
      n = 0;
      while (chop !== v && n < 1100) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask : wait_lvl
   initial begin
      int n;
      void'($urandom(96462));
      do_reset();
      rd(0, 0, 6);
      chk_ctl();
      analog_power_on_reset = 1'b1;
      load();
      rd(1, 0, 6);
      rd(0, 4, 1);
      load();
      wr(1, 127, 7, 8'h3a);
      rd(1, 126, 8);
      chk_ctl();
      for (int i = 0; i < 16; i++) begin
         wr(1'(i), 5, 1, {3'($urandom), 4'(i), 1'($urandom)});
         chk_ctl();
      end
      tick_hold = 1'b1;
      for (int s = 1; s < 4; s++) begin
         wr(0, 5, 1, {1'b0, 2'(s), 5'h05});
         wait_lvl(1'b1, n);
         wait_lvl(1'b0, n);
         wait_lvl(1'b1, n);
         check("chopper half period", 16'(64 << s), 16'(n));
      end
      wr(0, 5, 1, 8'h05);
      wait_lvl(1'b0, n);
      check("chopper held high", 16'd1100, 16'(n));
      tick_hold = 1'b0;
      analog_power_on_reset = 1'b0;
      load();
      do_reset();
      rd(0, 0, 6);
      chk_ctl();
      give_verdict();
   end
   initial begin
      repeat (80000) @(posedge clk);
      failures++;
      give_verdict();
   end
endmodule : test_adc_result_status_filter_regs
